// ===== rei_monitor_pkg.sv
// Purpose: Shared constants and carriers for the line remote error monitor
// Assumes: 8-bit processor port with 16-bit byte addresses
// Notes: Only remote error and remote defect bits are live in the status bytes
package rei_monitor_pkg;

    localparam logic [15:0] ADDR_CTRL = 16'h1103;
    localparam logic [15:0] ADDR_IRQ_HI = 16'h1109;
    localparam logic [15:0] ADDR_IRQ_LO = 16'h110B;
    localparam logic [15:0] ADDR_CNT_B3 = 16'h1118;
    localparam logic [15:0] ADDR_CNT_B2 = 16'h1119;
    localparam logic [15:0] ADDR_CNT_B1 = 16'h111A;
    localparam logic [15:0] ADDR_CNT_B0 = 16'h111B;

    localparam int CTRL_SF_EN_BIT = 6;
    localparam int CTRL_SD_EN_BIT = 5;
    localparam int CTRL_DESCR_DIS_BIT = 4;
    localparam int CTRL_STD_SEL_BIT = 3;
    localparam int CTRL_REI_TYPE_BIT = 2;
    localparam int CTRL_B2_TYPE_BIT = 1;
    localparam int CTRL_B1_TYPE_BIT = 0;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    localparam int IRQ_LO_REI_BIT = 5;
    localparam int IRQ_HI_RDL_BIT = 0;

    localparam logic [2:0] RDL_PATTERN = 3'h6;
    localparam int RDL_FRAMES_DEFAULT = 5;
    localparam int COUNT_WIDTH = 32;

    typedef struct packed {
        logic valid;
        logic [7:0] m1;
        logic [7:0] k2;
    } frame_in_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } up_req_type;

endpackage : rei_monitor_pkg

// ===== line_remote_error_monitor.sv
// Purpose: Line remote error and remote defect monitor of the receive overhead path
// Assumes: Frame strobe and processor port are synchronous to clk
// Notes: Counter reads are coherent when the most significant byte is read first
//
// Operation
// - Inspect the remote error field of M1 in every received frame.
// - Non-zero remote error sets bit 5 of status register 0x110B.
// - Same event drives the active-low interrupt output low.
// - Keep a 32-bit remote error counter, bumped by errored frames.
// - Counter read as four bytes, bits 31:24 at 0x1118 to 7:0 at 0x111B.
// - Counting type zero adds the received remote error value itself.
// - Counting type one adds exactly one per errored frame.
// - Control 0x1103 bits 7 to 3: unused, SF, SD, descramble, standard.
// - Control bits 2 to 0: remote error, B2 and B1 counting types.
// - Status 0x110B bits SF, SD, remote error, B2, B1, LOF, SEF, LOS; all but remote error read zero.
// - Status 0x1109 bit 0 flags remote defect change; upper bits read zero.
// - Remote defect declared or cleared after five frames; each change flags.
`timescale 1ns/1ns
module line_remote_error_monitor
    import rei_monitor_pkg::*;
#(
    parameter int RDL_FRAMES = RDL_FRAMES_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire frame_in_type frame_in,
    input wire up_req_type up_req,
    output logic [7:0] up_rdata,
    output logic int_n,
    output logic [6:0] ctrl_fields,
    output logic rdl_defect
);

    // The run counter is three bits wide, so longer runs cannot be served
    if (RDL_FRAMES < 1 || RDL_FRAMES > 7) begin : g_bad_frames
        $error("RDL_FRAMES must lie between 1 and 7");
    end

    logic [6:0] ctrl_q;
    logic rei_flag_q;
    logic rei_flag_d;
    logic rdl_flag_q;
    logic rdl_flag_d;
    logic rdl_defect_q;
    logic [2:0] rdl_run_q;
    logic [COUNT_WIDTH-1:0] count_q;
    logic [COUNT_WIDTH-1:0] count_d;
    logic [COUNT_WIDTH-1:0] snap_q;
    logic [7:0] rd_data_q;
    logic int_n_q;
    logic rei_event;
    logic rdl_match;
    logic rdl_change;
    logic [7:0] rei_inc;

    function automatic logic hit(input up_req_type req, input logic [15:0] a);
        hit = req.rd && (req.addr == a);
    endfunction : hit

    assign rei_event = frame_in.valid && (frame_in.m1 != 8'h00);
    assign rdl_match = frame_in.k2[2:0] == RDL_PATTERN;
    assign rdl_change = frame_in.valid && (rdl_match != rdl_defect_q)
        && (rdl_run_q == 3'(RDL_FRAMES - 1));

    // Set wins over a read in the same cycle so no event is lost
    always_comb begin
        rei_flag_d = rei_event || (rei_flag_q && !hit(up_req, ADDR_IRQ_LO));
        rdl_flag_d = rdl_change || (rdl_flag_q && !hit(up_req, ADDR_IRQ_HI));
    end

    // Field value is taken as sent; the far end keeps it within 1 to 24
    always_comb begin
        if (!rei_event) begin
            rei_inc = 8'h00;
        end else if (ctrl_q[CTRL_REI_TYPE_BIT]) begin
            rei_inc = 8'h01;
        end else begin
            rei_inc = frame_in.m1;
        end
        count_d = (hit(up_req, ADDR_CNT_B3) ? '0 : count_q) + COUNT_WIDTH'(rei_inc);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (clk_en && up_req.wr && up_req.addr == ADDR_CTRL) begin
            ctrl_q <= up_req.wdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rei_flag_q <= 1'b0;
            rdl_flag_q <= 1'b0;
            int_n_q <= 1'b1;
        end else if (clk_en) begin
            rei_flag_q <= rei_flag_d;
            rdl_flag_q <= rdl_flag_d;
            int_n_q <= !(rei_flag_d || rdl_flag_d);
        end
    end

    // Run counter restarts whenever a frame agrees with the current state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdl_run_q <= 3'h0;
            rdl_defect_q <= 1'b0;
        end else if (clk_en && frame_in.valid) begin
            if (rdl_match == rdl_defect_q) begin
                rdl_run_q <= 3'h0;
            end else if (rdl_change) begin
                rdl_run_q <= 3'h0;
                rdl_defect_q <= rdl_match;
            end else begin
                rdl_run_q <= rdl_run_q + 3'h1;
            end
        end
    end

    // Reading the top byte copies the count into the snapshot and restarts it from zero, so the lower bytes stay coherent
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= '0;
            snap_q <= '0;
        end else if (clk_en) begin
            count_q <= count_d;
            if (hit(up_req, ADDR_CNT_B3)) begin
                snap_q <= count_q;
            end else if (hit(up_req, ADDR_CNT_B2)) begin
                snap_q[23:16] <= 8'h00;
            end else if (hit(up_req, ADDR_CNT_B1)) begin
                snap_q[15:8] <= 8'h00;
            end else if (hit(up_req, ADDR_CNT_B0)) begin
                snap_q[7:0] <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
        end else if (clk_en && up_req.rd) begin
            case (up_req.addr)
                ADDR_CTRL: rd_data_q <= {1'b0, ctrl_q};
                ADDR_IRQ_HI: rd_data_q <= {7'h00, rdl_flag_q};
                ADDR_IRQ_LO: rd_data_q <= {2'h0, rei_flag_q, 5'h00};
                ADDR_CNT_B3: rd_data_q <= count_q[31:24];
                ADDR_CNT_B2: rd_data_q <= snap_q[23:16];
                ADDR_CNT_B1: rd_data_q <= snap_q[15:8];
                ADDR_CNT_B0: rd_data_q <= snap_q[7:0];
                default: rd_data_q <= 8'h00;
            endcase
        end
    end

    assign up_rdata = rd_data_q;
    assign int_n = int_n_q;
    assign ctrl_fields = ctrl_q;
    assign rdl_defect = rdl_defect_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_rei_flag_set: assert property (
        clk_en && rei_event |=> rei_flag_q)
        else $error("remote error flag not set");

    a_int_follows_flags: assert property (
        ##1 (int_n_q == !(rei_flag_q || rdl_flag_q)))
        else $error("interrupt output disagrees with flags");

    a_count_by_value: assert property (
        clk_en && rei_event && !ctrl_q[CTRL_REI_TYPE_BIT] && !up_req.rd
        |=> count_q == $past(count_q) + COUNT_WIDTH'($past(frame_in.m1)))
        else $error("value mode count wrong");

    a_count_by_frame: assert property (
        clk_en && rei_event && ctrl_q[CTRL_REI_TYPE_BIT] && !up_req.rd
        |=> count_q == $past(count_q) + 1)
        else $error("frame mode count wrong");

    a_zero_frame_quiet: assert property (
        clk_en && !rei_event && !up_req.rd |=> $stable(count_q) && $stable(rei_flag_q))
        else $error("clean frame changed state");

    a_rdl_declare: assert property (
        clk_en && frame_in.valid && rdl_match && !rdl_defect_q
        && rdl_run_q == 3'(RDL_FRAMES - 1) |=> rdl_defect_q && rdl_flag_q)
        else $error("remote defect not declared");

    a_ctrl_readback: assert property (
        clk_en && hit(up_req, ADDR_CTRL) |=> rd_data_q == {1'b0, $past(ctrl_q)})
        else $error("control readback wrong");

    a_flag_read_clear: assert property (
        clk_en && hit(up_req, ADDR_IRQ_LO) && !rei_event
        |=> !rei_flag_q && rd_data_q[IRQ_LO_REI_BIT] == $past(rei_flag_q))
        else $error("status read did not return then clear");

    a_count_top_byte: assert property (
        clk_en && hit(up_req, ADDR_CNT_B3)
        |=> rd_data_q == $past(count_q[31:24]) && snap_q == $past(count_q))
        else $error("counter top byte read wrong");

    a_snap_byte_clear: assert property (
        clk_en && hit(up_req, ADDR_CNT_B2)
        |=> rd_data_q == $past(snap_q[23:16]) && snap_q[23:16] == 8'h00)
        else $error("counter byte read did not return then clear");

    a_rdl_clear: assert property (
        clk_en && frame_in.valid && !rdl_match && rdl_defect_q
        && rdl_run_q == 3'(RDL_FRAMES - 1) |=> !rdl_defect_q && rdl_flag_q)
        else $error("remote defect not cleared");

    c_value_count: cover property (clk_en && rei_event && !ctrl_q[CTRL_REI_TYPE_BIT]);
    c_frame_count: cover property (clk_en && rei_event && ctrl_q[CTRL_REI_TYPE_BIT]);
    c_rdl_declared: cover property ($rose(rdl_defect_q));
    c_set_on_clear: cover property (clk_en && rei_event && hit(up_req, ADDR_IRQ_LO));

endmodule : line_remote_error_monitor

// ===== far_end_model.sv
// Purpose: Far-end line equipment model feeding overhead bytes to the monitor
// Assumes: Frames launch on the next rising edge; they may run back to back
// Notes: Bytes are inverted between frames so a stale value never looks valid
`timescale 1ns/1ns
module far_end_model
    import rei_monitor_pkg::*;
(
    input wire logic clk,
    output frame_in_type frame_in
);
    initial frame_in = '{valid: 1'h0, m1: 8'hA5, k2: 8'h5A};
    task automatic send(input logic [7:0] rei, input logic [7:0] kv, input int n);
        @(posedge clk);
        repeat (n) begin
            frame_in <= '{valid: 1'h1, m1: rei, k2: kv};
            @(posedge clk);
        end
        frame_in <= '{valid: 1'h0, m1: ~rei, k2: ~kv};
    endtask : send
endmodule : far_end_model

// ===== line_remote_error_monitor_tb.sv
// Purpose: Self-checking bench for the line remote error monitor
// Assumes: Frames come from far_end_model; one register access at a time
// Notes: Counter is always read most significant byte first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module line_remote_error_monitor_tb
    import rei_monitor_pkg::*;
;
    typedef struct packed {logic ty; logic [7:0] m1; logic [31:0] add;} row_type;
    localparam row_type ROWS [6] = '{'{1'h0, 8'h00, 32'h0}, '{1'h0, 8'h01, 32'h1},
        '{1'h0, 8'h18, 32'h18}, '{1'h1, 8'h18, 32'h1}, '{1'h1, 8'h01, 32'h1},
        '{1'h1, 8'h00, 32'h0}};
    logic clk, sys_rst, clk_en, int_n, rdl_defect;
    frame_in_type frame_in;
    up_req_type up_req;
    logic [7:0] up_rdata, rv;
    logic [6:0] ctrl_fields;
    logic [31:0] cnt;
    int n_mismatch, cmp_count;
    line_remote_error_monitor u_line_remote_error_monitor (.clk(clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .frame_in(frame_in), .up_req(up_req), .up_rdata(up_rdata),
        .int_n(int_n), .ctrl_fields(ctrl_fields), .rdl_defect(rdl_defect));
    far_end_model u_far_end_model (.clk(clk), .frame_in(frame_in));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        up_req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        up_req <= '{rd: 1'h0, wr: 1'h0, addr: a, wdata: d};
        #1 rv = up_rdata;
    endtask : bus
    task automatic rd_count();
        for (int i = 0; i < 4; i++) begin
            bus(1'h0, ADDR_CNT_B3 + 16'(i), 8'h00);
            cnt = {cnt[23:0], rv};
        end
    endtask : rd_count
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        #(40 * 20000);
        n_mismatch++;
        complete_run();
    end
    initial begin
        clk_en = 1'h1;
        sys_rst = 1'h1;
        up_req = '0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        foreach (ROWS[i]) begin
            bus(1'h1, ADDR_CTRL, {5'h00, ROWS[i].ty, 2'h0});
            u_far_end_model.send(ROWS[i].m1, 8'h00, 1);
            #1 `CHK("int_n", ROWS[i].m1 == 8'h00, int_n)
            bus(1'h0, ADDR_IRQ_LO, 8'h00);
            `CHK("status", (ROWS[i].m1 != 8'h00) ? 8'h20 : 8'h00, rv)
            rd_count();
            `CHK("count", ROWS[i].add, cnt)
            $display("row %0d done", i);
        end
        // Bit 7 is read-only, so an all-ones write must read back without it
        bus(1'h1, ADDR_CTRL, 8'hFF);
        bus(1'h0, ADDR_CTRL, 8'h00);
        `CHK("ctrl", 8'h7F, rv)
        `CHK("fields", 7'h7F, ctrl_fields)
        bus(1'h1, ADDR_CTRL, 8'h00);
        u_far_end_model.send(8'h18, 8'h00, 11);
        bus(1'h1, ADDR_CNT_B0, 8'h55);
        bus(1'h0, ADDR_IRQ_LO, 8'h00);
        `CHK("status", 8'h20, rv)
        bus(1'h0, ADDR_IRQ_LO, 8'h00);
        `CHK("cleared", 8'h00, rv)
        rd_count();
        `CHK("bytes", 32'h108, cnt)
        rd_count();
        `CHK("count zero", 32'h0, cnt)
        bus(1'h0, 16'h1100, 8'h00);
        `CHK("unmapped", 8'h00, rv)
        $display("register test done");
        u_far_end_model.send(8'h00, 8'h06, 4);
        #1 `CHK("rdl early", 1'h0, rdl_defect)
        u_far_end_model.send(8'h00, 8'h06, 1);
        #1 `CHK("rdl set", 1'h1, rdl_defect)
        `CHK("rdl irq", 1'h0, int_n)
        bus(1'h0, ADDR_IRQ_HI, 8'h00);
        `CHK("hi status", 8'h01, rv)
        u_far_end_model.send(8'h00, 8'h02, 5);
        #1 `CHK("rdl clear", 1'h0, rdl_defect)
        bus(1'h0, ADDR_IRQ_HI, 8'h00);
        `CHK("hi again", 8'h01, rv)
        $display("remote defect test done");
        // Clock enable low must drop a frame: no flag, interrupt or count follows
        @(posedge clk);
        clk_en <= 1'h0;
        u_far_end_model.send(8'h05, 8'h00, 1);
        clk_en <= 1'h1;
        #1 `CHK("frozen int_n", 1'h1, int_n)
        rd_count();
        `CHK("frozen count", 32'h0, cnt)
        // A frame landing with the status read keeps the flag; the read sees the old value
        fork
            bus(1'h0, ADDR_IRQ_LO, 8'h00);
            u_far_end_model.send(8'h05, 8'h00, 1);
        join
        `CHK("set wins", 8'h00, rv)
        bus(1'h0, ADDR_IRQ_LO, 8'h00);
        `CHK("kept", 8'h20, rv)
        $display("awkward test done");
        // Reset in mid-run must drop a pending flag and a non-zero count
        bus(1'h1, ADDR_CTRL, 8'h04);
        u_far_end_model.send(8'h05, 8'h00, 1);
        sys_rst <= 1'h1;
        @(posedge clk);
        sys_rst <= 1'h0;
        #1 `CHK("rst int_n", 1'h1, int_n)
        `CHK("rst ctrl", 7'h00, ctrl_fields)
        `CHK("rst rdata", 8'h00, up_rdata)
        `CHK("rst rdl", 1'h0, rdl_defect)
        rd_count();
        `CHK("rst count", 32'h0, cnt)
        $display("reset test done");
        complete_run();
    end
endmodule : line_remote_error_monitor_tb
